// File: dv/bstc_tap_asserts.sv
`timescale 1ns/1ns
`default_nettype none

module bstc_tap_asserts (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Watched pins.
	input wire logic tck,
	input wire logic tms,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic [76:0] core_out,
	input wire logic [76:0] pin_out
);
	logic tck_q, tms_q;
	logic [3:0] fall_n, high_n;

	// Clocks since the last test clock fall, and the run of high mode samples.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tck_q <= 1'b0;
			tms_q <= 1'b0;
			fall_n <= 4'hF;
			high_n <= 4'h0;
		end else begin
			tck_q <= tck;
			fall_n <= (tck_q && !tck) ? 4'h1 : fall_n + {3'h0, fall_n != 4'hF};
			if (tck && !tck_q) begin
				tms_q <= tms;
				high_n <= tms ? high_n + {3'h0, high_n != 4'hF} : 4'h0;
			end
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	chk_tdo_quiet: assert property (!tdo_oe |-> tdo == 1'b0)
		else $error("tdo driven while idle");
	chk_tdo_on_fall: assert property ($changed(tdo) |-> fall_n inside {[1:6]})
		else $error("tdo moved away from a fall");
	chk_oe_on_fall: assert property ($changed(tdo_oe) |-> fall_n inside {[1:6]})
		else $error("tdo_oe moved away from a fall");
	chk_shift_entry: assert property ($rose(tdo_oe) |-> !tms_q)
		else $error("shift entered with mode high");
	chk_shift_exit: assert property ($fell(tdo_oe) |-> tms_q)
		else $error("shift left with mode low");
	chk_shift_width: assert property ($rose(tdo_oe) |-> tdo_oe [*7])
		else $error("shift shorter than a period");
	chk_pins_held: assert property ($past(tdo_oe) && tdo_oe
		&& $stable(core_out) |-> $stable(pin_out)) else $error("pins moved during shift");
	chk_tms_reset: assert property (high_n >= 4'h5
		|-> ##6 (pin_out == core_out && !tdo_oe)) else $error("no reset after high mode run");
	chk_reset_clean: assert property ($fell(reset) |-> pin_out == core_out && !tdo_oe)
		else $error("test logic active after reset");
endmodule : bstc_tap_asserts

`default_nettype wire

// File: dv/bstc_tester.sv
`timescale 1ns/1ns
`default_nettype none

// Behavioural tester; the test clock stands low between periods.
module bstc_tester (
	// System clock.
	input wire logic clk_sys,
	// Test access pins.
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One test clock period; TDO is read just before the rise.
	task automatic step(input logic m, input logic d, output logic so);
		@(negedge clk_sys);
		tms = m;
		tdi = d;
		repeat (3) @(negedge clk_sys);
		so = tdo;
		tck = 1'b1;
		repeat (4) @(negedge clk_sys);
		tck = 1'b0;
		tdi = ~d; // Released data shows the inverse, so stale bits never pass.
	endtask : step

	// Five high samples reach test-logic reset, then one low goes to idle.
	task automatic to_idle();
		logic s;
		repeat (5) step(1'b1, 1'b0, s);
		step(1'b0, 1'b0, s);
	endtask : to_idle

	// Instruction scan from idle, LSB first.
	task automatic scan_ir(input logic [2:0] code);
		logic s;
		step(1'b1, 1'b0, s);
		step(1'b1, 1'b0, s);
		step(1'b0, 1'b0, s);
		step(1'b0, 1'b0, s);
		for (int i = 0; i < 3; i++) step(i == 2, code[i], s);
		step(1'b1, 1'b0, s);
		step(1'b0, 1'b0, s);
	endtask : scan_ir

	// Data scan of n bits from idle, ending in idle after update.
	task automatic scan_dr(input logic [76:0] din, input int n, output logic [76:0] dout);
		logic s;
		dout = '0;
		step(1'b1, 1'b0, s);
		step(1'b0, 1'b0, s);
		step(1'b0, 1'b0, s);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], s);
			dout[i] = s;
		end
		step(1'b1, 1'b0, s);
		step(1'b0, 1'b0, s);
	endtask : scan_dr
endmodule : bstc_tester

`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "bstc_params.svh"

module testbench;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic tck, tms, tdi, tdo, tdo_oe, bit_s;
	logic [76:0] pin_in, core_out, pin_out, got, exp, pat, latch;
	logic [2:0] codes [5] = '{3'h2, 3'h0, 3'h3, 3'h7, 3'h5};
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;

	// System clock of 100 ns.
	always #50 clk_sys = ~clk_sys;

	bstc_tap dut (.clk_sys(clk_sys), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out));
	bstc_tester tst (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	function automatic logic [76:0] rnd();
		logic [95:0] r;
		r = {$urandom(), $urandom(), $urandom()};
		return r[76:0];
	endfunction : rnd

	task automatic check(input logic [76:0] seen, input logic [76:0] want);
		tests_run++;
		if (seen !== want) begin
			n_fail++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask : check

	task automatic end_sim();
		if (n_fail == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	// Hang guard; the run needs about half of this.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 10000) begin
			n_fail++;
			end_sim();
		end
	end

	// Reset, identification, every instruction, idle hold and a mid-shift abort.
	initial begin
		void'($urandom(32'h7491C256));
		pin_in = rnd();
		core_out = rnd();
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		@(negedge clk_sys);
		check(pin_out, core_out);
		check(77'(tdo_oe), 77'h0);
		tst.to_idle();
		tst.scan_dr(rnd(), 32, got);
		check(77'(got[31:0]), 77'(`BSTC_IDCODE_VALUE));
		latch = '0;
		foreach (codes[k]) begin
			tst.scan_ir(codes[k]);
			if (codes[k] == 3'h0) check(pin_out, latch);
			pin_in = rnd();
			core_out = rnd();
			pat = rnd();
			exp = (pin_in & ~`BSTC_OUT_CELL_MASK) | (core_out & `BSTC_OUT_CELL_MASK);
			tst.scan_dr(pat, 77, got);
			if (codes[k] == 3'h0 || codes[k] == 3'h2) begin
				check(got, exp);
				latch = pat;
			end else begin
				check({got[76:1], 1'b0}, {pat[75:0], 1'b0});
			end
			check(pin_out, (codes[k] == 3'h0 || codes[k] == 3'h3) ? latch : core_out);
		end
		tst.scan_ir(3'h0);
		for (int i = 0; i < 6; i++) begin
			core_out = rnd();
			pin_in = rnd();
			tst.step(1'b0, 1'b0, bit_s);
			check(pin_out, latch);
		end
		tst.step(1'b1, 1'b0, bit_s);
		tst.step(1'b0, 1'b0, bit_s);
		tst.step(1'b0, 1'b0, bit_s);
		tst.to_idle();
		check(pin_out, core_out);
		tst.scan_dr(rnd(), 32, got);
		check(77'(got[31:0]), 77'(`BSTC_IDCODE_VALUE));
		// Second reset while clamp holds the pins on the latch.
		tst.scan_ir(3'h3);
		reset = 1'b1;
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		@(negedge clk_sys);
		check(pin_out, core_out);
		check(77'(tdo_oe), 77'h0);
		tst.to_idle();
		tst.scan_dr(rnd(), 32, got);
		check(77'(got[31:0]), 77'(`BSTC_IDCODE_VALUE));
		end_sim();
	end
endmodule : testbench

bind bstc_tap bstc_tap_asserts chk (.clk_sys(clk_sys), .reset(reset), .tck(tck), .tms(tms),
	.tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .pin_out(pin_out));

`default_nettype wire

// File: rtl/bstc_chain.sv
`timescale 1ns/1ns
`default_nettype none
`include "bstc_params.svh"

module bstc_chain import bstc_pkg::*; (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Controller side.
	bstc_chain_if.chain ctl,
	// Pins and core.
	input wire logic [`BSTC_CHAIN_LEN-1:0] pin_in,
	input wire logic [`BSTC_CHAIN_LEN-1:0] core_out,
	output logic [`BSTC_CHAIN_LEN-1:0] pin_out
);

	typedef struct packed {
		logic [`BSTC_CHAIN_LEN-1:0] pin_s1;
		logic [`BSTC_CHAIN_LEN-1:0] pin_s2;
		logic [`BSTC_CHAIN_LEN-1:0] sh;
		logic [`BSTC_CHAIN_LEN-1:0] upd;
	} bstc_chain_st_t;

	bstc_chain_st_t q, d;
	logic [`BSTC_CHAIN_LEN-1:0] cap_val;
	// Bit n-1 is high when cell n is an output cell.
	localparam logic [`BSTC_CHAIN_LEN-1:0] out_cell_mask = `BSTC_OUT_CELL_MASK;

	// Input cells only observe their pin, output cells observe what the core drives.
	always_comb begin
		for (int i = 0; i < `BSTC_CHAIN_LEN; i++) begin
			cap_val[i] = out_cell_mask[i] ? core_out[i] : q.pin_s2[i];
		end
	end

	// Shift stages load on capture and move on shift, the parallel latch only on update.
	always_comb begin
		d = q;
		d.pin_s1 = pin_in;
		d.pin_s2 = q.pin_s1;
		if (ctl.capture) begin
			d.sh = cap_val;
		end else if (ctl.shift) begin
			d.sh = {ctl.sdi, q.sh[`BSTC_CHAIN_LEN-1:1]};
		end
		if (ctl.update) begin
			d.upd = q.sh;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Every cell, input cells included, takes its pin over only under external test or clamp.
	always_comb begin
		for (int i = 0; i < `BSTC_CHAIN_LEN; i++) begin
			pin_out[i] = ctl.drive_ext ? q.upd[i] : core_out[i];
		end
	end

	assign ctl.sdo = q.sh[0];

endmodule : bstc_chain

`default_nettype wire

// File: rtl/bstc_chain_if.sv
`timescale 1ns/1ns
`default_nettype none

// Control and serial data between the controller and the boundary chain.
interface bstc_chain_if;
	logic capture;
	logic shift;
	logic update;
	logic sdi;
	logic sdo;
	logic drive_ext;

	modport tap (output capture, output shift, output update, output sdi,
		output drive_ext, input sdo);
	modport chain (input capture, input shift, input update, input sdi,
		input drive_ext, output sdo);
endinterface : bstc_chain_if

`default_nettype wire

// File: rtl/bstc_params.svh
`ifndef BSTC_PARAMS_SVH
`define BSTC_PARAMS_SVH

// Chain and register sizes.
`define BSTC_CHAIN_LEN 77
`define BSTC_IR_LEN 3
`define BSTC_ID_LEN 32

// Cells of the chain that are output cells, bit n-1 stands for cell n.
`define BSTC_OUT_CELL_MASK 77'h1_2555_5460_08B7_B16F_606

// Output enable cells that control groups of pins, as bit indices.
`define BSTC_DATA_BUS_OUTPUT_ENABLE_CELL 7'h36
`define BSTC_TRANSMIT_CLOCK_FRAME_ENABLE_CELL 7'h12
`define BSTC_RECEIVE_DATA_SIGNAL_ENABLE_CELL 7'h0D
`define BSTC_RECEIVE_CLOCK_FRAME_ENABLE_CELL 7'h0A

// Identification word; the value is arbitrary, bit 0 is always set.
`define BSTC_IDCODE_VALUE 32'h1234_5671

// Fixed pattern that the instruction shift stage takes in capture.
`define BSTC_IR_CAPTURE 3'h4

`endif

// File: rtl/bstc_pkg.sv
`default_nettype none

package bstc_pkg;

	// Controller states.
	typedef enum logic [3:0] {
		BSTC_TLR = 4'h0,
		BSTC_RTI = 4'h1,
		BSTC_SEL_DR = 4'h2,
		BSTC_CAP_DR = 4'h3,
		BSTC_SHIFT_DR = 4'h4,
		BSTC_EXIT1_DR = 4'h5,
		BSTC_PAUSE_DR = 4'h6,
		BSTC_EXIT2_DR = 4'h7,
		BSTC_UPD_DR = 4'h8,
		BSTC_SEL_IR = 4'h9,
		BSTC_CAP_IR = 4'hA,
		BSTC_SHIFT_IR = 4'hB,
		BSTC_EXIT1_IR = 4'hC,
		BSTC_PAUSE_IR = 4'hD,
		BSTC_EXIT2_IR = 4'hE,
		BSTC_UPD_IR = 4'hF
	} bstc_state_t;

	// Instruction codes.
	typedef enum logic [2:0] {
		BSTC_I_EXTEST = 3'h0,
		BSTC_I_IDCODE = 3'h1,
		BSTC_I_SAMPLE = 3'h2,
		BSTC_I_CLAMP = 3'h3,
		BSTC_I_MFG = 3'h5,
		BSTC_I_BYPASS = 3'h7
	} bstc_ir_t;

endpackage : bstc_pkg

`default_nettype wire

// File: rtl/bstc_tap.sv
// Operation
// - Each two-way pin has an input cell and an output cell; under external test or clamp every cell drives its pin_out bit.
// - The chain holds cells 1 to 77 in fixed order, enable cells included.
// - Sixteen-state controller steered by TMS at each rising TCK edge.
// - Test-logic reset leaves pins normal and presets the identification instruction.
// - Five or more high TMS samples reach test-logic reset from anywhere.
// - Run-test/idle holds while TMS low, registers unchanged; high goes to select-DR.
// - Select-DR goes to capture-DR on low, select-IR on high, data kept.
// - Instruction stays constant through select-DR, capture-DR and shift-DR.
// - Capture-DR loads pins into the chain only under external test or sample.
// - Capture-DR goes to exit1-DR on high TMS, shift-DR on low.
// - Shift-DR moves the selected register one stage toward TDO per rising edge.
// - Identification code is 001, bypass code is 111.
// - Exit1-DR goes to update-DR on high, pause-DR on low, data kept.
`timescale 1ns/1ns
`default_nettype none
`include "bstc_params.svh"

module bstc_tap import bstc_pkg::*; (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Test access pins.
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// Boundary pins and core.
	input wire logic [`BSTC_CHAIN_LEN-1:0] pin_in,
	input wire logic [`BSTC_CHAIN_LEN-1:0] core_out,
	output logic [`BSTC_CHAIN_LEN-1:0] pin_out
);

	// Every register of the controller, kept in one record.
	typedef struct packed {
		logic [2:0] tck_s;
		logic [1:0] tms_s;
		logic [1:0] tdi_s;
		bstc_state_t st;
		logic [`BSTC_IR_LEN-1:0] ir_sh;
		bstc_ir_t ir;
		logic [`BSTC_ID_LEN-1:0] id_sh;
		logic byp;
		logic tdo;
		logic tdo_oe;
	} bstc_tap_st_t;

	// Present and next value of the record, and the link to the chain.
	bstc_tap_st_t q, d;
	bstc_chain_if chain_bus ();

	// Decoded test clock edges, synchronised levels and instruction decode.
	// All of them are combinational views of the record above.
	logic tck_rise;
	logic tck_fall;
	logic tms_v;
	logic tdi_v;
	logic sel_bnd;
	logic sel_id;

	// Next controller state for a rising edge with the given TMS level.
	// Both scan branches are decoded, so any mode sequence is legal.
	function automatic bstc_state_t tap_next(input bstc_state_t s, input logic m);
		unique case (s)
			BSTC_TLR: tap_next = m ? BSTC_TLR : BSTC_RTI;
			BSTC_RTI: tap_next = m ? BSTC_SEL_DR : BSTC_RTI;
			BSTC_SEL_DR: tap_next = m ? BSTC_SEL_IR : BSTC_CAP_DR;
			BSTC_CAP_DR: tap_next = m ? BSTC_EXIT1_DR : BSTC_SHIFT_DR;
			BSTC_SHIFT_DR: tap_next = m ? BSTC_EXIT1_DR : BSTC_SHIFT_DR;
			BSTC_EXIT1_DR: tap_next = m ? BSTC_UPD_DR : BSTC_PAUSE_DR;
			BSTC_PAUSE_DR: tap_next = m ? BSTC_EXIT2_DR : BSTC_PAUSE_DR;
			BSTC_EXIT2_DR: tap_next = m ? BSTC_UPD_DR : BSTC_SHIFT_DR;
			BSTC_UPD_DR: tap_next = m ? BSTC_SEL_DR : BSTC_RTI;
			BSTC_SEL_IR: tap_next = m ? BSTC_TLR : BSTC_CAP_IR;
			BSTC_CAP_IR: tap_next = m ? BSTC_EXIT1_IR : BSTC_SHIFT_IR;
			BSTC_SHIFT_IR: tap_next = m ? BSTC_EXIT1_IR : BSTC_SHIFT_IR;
			BSTC_EXIT1_IR: tap_next = m ? BSTC_UPD_IR : BSTC_PAUSE_IR;
			BSTC_PAUSE_IR: tap_next = m ? BSTC_EXIT2_IR : BSTC_PAUSE_IR;
			BSTC_EXIT2_IR: tap_next = m ? BSTC_UPD_IR : BSTC_SHIFT_IR;
			BSTC_UPD_IR: tap_next = m ? BSTC_SEL_DR : BSTC_RTI;
		endcase
	endfunction : tap_next

	// True when the instruction routes the boundary chain between TDI and TDO.
	// Sample and external test both capture the pins, so they share this path.
	function automatic logic selects_chain(input bstc_ir_t i);
		selects_chain = (i == BSTC_I_EXTEST) || (i == BSTC_I_SAMPLE);
	endfunction : selects_chain

	// True when the instruction hands the output pins to the boundary latch.
	// Clamp keeps pins on the latch while the bypass bit is in the path.
	function automatic logic drives_pins(input bstc_ir_t i);
		drives_pins = (i == BSTC_I_EXTEST) || (i == BSTC_I_CLAMP);
	endfunction : drives_pins

	// Edges are found only from the second sync stage onward.
	// The test pins come from another clock, so each passes two flip-flops first,
	// and a third stage of the test clock marks its edges. Every test clock edge
	// therefore acts three system clocks after it reaches the pin.
	// Mode and data ride through the same two stages, so they line up with the
	// edge that the controller acts on and need no hold time beyond one level.
	// Limitation: each test clock level must last at least four system clocks,
	// otherwise an edge can be missed or act with stale mode and data.
	// The price is latency; the gain is that no logic runs on the test clock.
	assign tck_rise = q.tck_s[1] & ~q.tck_s[2];
	assign tck_fall = ~q.tck_s[1] & q.tck_s[2];
	assign tms_v = q.tms_s[1];
	assign tdi_v = q.tdi_s[1];
	assign sel_bnd = selects_chain(q.ir);
	assign sel_id = (q.ir == BSTC_I_IDCODE);

	// Strobes to the chain; the update lands on the falling edge so pins settle mid-cycle.
	assign chain_bus.capture = tck_rise && q.st == BSTC_CAP_DR && sel_bnd;
	assign chain_bus.shift = tck_rise && q.st == BSTC_SHIFT_DR && sel_bnd;
	assign chain_bus.update = tck_fall && q.st == BSTC_UPD_DR && sel_bnd;
	assign chain_bus.sdi = tdi_v;
	// Output cells take the pins over only while the instruction asks for it.
	assign chain_bus.drive_ext = drives_pins(q.ir);

	// Controller, instruction and small data registers.
	always_comb begin
		d = q;
		// Synchroniser stages advance on every clock.
		d.tck_s = {q.tck_s[1:0], tck};
		d.tms_s = {q.tms_s[0], tms};
		d.tdi_s = {q.tdi_s[0], tdi};
		// On a test clock rise the state moves and the selected register captures or shifts.
		if (tck_rise) begin
			d.st = tap_next(q.st, tms_v);
			unique case (q.st)
				BSTC_CAP_DR: begin
					// Bypass has no parallel input, so capture leaves it alone.
					if (sel_id) begin
						d.id_sh = `BSTC_IDCODE_VALUE;
					end
				end
				BSTC_SHIFT_DR: begin
					// Only the selected data register moves; the others hold.
					// The chain shifts in its own module on the same strobe.
					if (sel_id) begin
						d.id_sh = {tdi_v, q.id_sh[`BSTC_ID_LEN-1:1]};
					end else if (!sel_bnd) begin
						d.byp = tdi_v;
					end
				end
				BSTC_CAP_IR: begin
					// Fixed pattern lets the tester check the serial path.
					d.ir_sh = `BSTC_IR_CAPTURE;
				end
				BSTC_SHIFT_IR: begin
					// Instruction bits enter from the data pin, least significant first.
					d.ir_sh = {tdi_v, q.ir_sh[`BSTC_IR_LEN-1:1]};
				end
				default: begin
					// Other states keep every register, run-test/idle included.
					d.byp = q.byp;
				end
			endcase
		end
		// On a test clock fall the instruction and the serial output move.
		if (tck_fall) begin
			// Instruction changes only here or in reset, never in the scan path.
			if (q.st == BSTC_UPD_IR) begin
				d.ir = bstc_ir_t'(q.ir_sh);
			end
			// Serial output is moved a half cycle ahead of the tester's sample.
			if (q.st == BSTC_SHIFT_DR) begin
				d.tdo = sel_bnd ? chain_bus.sdo : (sel_id ? q.id_sh[0] : q.byp);
				d.tdo_oe = 1'b1;
			end else if (q.st == BSTC_SHIFT_IR) begin
				d.tdo = q.ir_sh[0];
				d.tdo_oe = 1'b1;
			end else begin
				// Outside shift states the output rests low and undriven.
				d.tdo = 1'b0;
				d.tdo_oe = 1'b0;
			end
		end
		// Test logic is off in reset state and the identification code is preset.
		if (q.st == BSTC_TLR) begin
			d.ir = BSTC_I_IDCODE;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			// Mode idles high, so no false low sample follows reset.
			q <= '{
				tck_s: 3'h0,
				tms_s: 2'h3,
				tdi_s: 2'h0,
				st: BSTC_TLR,
				ir_sh: 3'h0,
				ir: BSTC_I_IDCODE,
				id_sh: 32'h0,
				byp: 1'b0,
				tdo: 1'b0,
				tdo_oe: 1'b0
			};
		end else begin
			q <= d;
		end
	end

	// Test data output and its enable come straight from flip-flops.
	assign tdo = q.tdo;
	assign tdo_oe = q.tdo_oe;

	// Boundary chain with its parallel latch.
	// It sees only one-cycle strobes, so it needs no edge logic of its own.
	bstc_chain u_chain (
		.clk_sys(clk_sys),
		.reset(reset),
		.ctl(chain_bus),
		.pin_in(pin_in),
		.core_out(core_out),
		.pin_out(pin_out)
	);

endmodule : bstc_tap

`default_nettype wire
